// *** src/nac_pkg.sv ***
// Package for the data EEPROM access controller: register selects, field
// positions, reset values and timing counts.
// Assumes a CPU-side special function register port of byte width.
//
// Operation
// RQ1: Small variant: seven address bits, bit7 zero.
// RQ2: Middle variant: eight address bits, reset zero.
// RQ3: Large variant: low byte plus high bit0.
// RQ4: Control: four low bits, upper read zero.
// RQ5: Bit3 permits writes; clear inhibits writes.
// RQ6: Bit2 starts write, cleared when done.
// RQ7: Write trigger ignored without prior permission.
// RQ8: Bit1 permits reads; clear inhibits reads.
// RQ9: Bit0 starts read, cleared when done.
// RQ10: Read trigger ignored without prior permission.
// RQ11: Software never sets both triggers together.
// RQ12: Software ensures slow clock stable first.
// RQ13: Software waits for write completion first.
// RQ14: Read byte held until next access.
// RQ15: Software loads address and data first.
// RQ16: Permission then trigger, consecutive cycles; the code accepts the trigger in any later cycle while permission stays set.
// RQ17: Software masks global interrupts around write.
// RQ18: Write time set by asynchronous timer.
// RQ19: Power-on clears write permission.
// RQ20: Write end sets both interrupt flags.
// RQ21: Vector only when all enables, stack room.
// RQ22: Software clears the interrupt flag.
// RQ23: Software rewrites address for every read.
// RQ24: Software avoids sleep during accesses.
package nac_pkg;

    // =========================================================
    // Register selects
    localparam logic [2:0] NAC_SEL_ADDR_LOW = 3'h0;
    localparam logic [2:0] NAC_SEL_ADDR_HIGH = 3'h1;
    localparam logic [2:0] NAC_SEL_BYTE_BUF = 3'h2;
    localparam logic [2:0] NAC_SEL_CONTROL = 3'h3;

    // =========================================================
    // Capacity variants
    localparam logic [1:0] NAC_CAP_128 = 2'h0;
    localparam logic [1:0] NAC_CAP_256 = 2'h1;
    localparam logic [1:0] NAC_CAP_512 = 2'h2;

    // =========================================================
    // Control fields
    localparam int NAC_BIT_READ_GO = 0;
    localparam int NAC_BIT_FETCH_PERMIT = 1;
    localparam int NAC_BIT_WRITE_GO = 2;
    localparam int NAC_BIT_PROGRAM_PERMIT = 3;
    localparam logic [7:0] NAC_RST_REG = 8'h00;
    localparam logic [8:0] NAC_RST_ADDR = 9'h000;

    // =========================================================
    // Timing
    localparam int NAC_CLK_MHZ = 25;
    localparam int NAC_READ_NS = 200;
    localparam int NAC_READ_CYC =
        (NAC_READ_NS * NAC_CLK_MHZ + 999) / 1000;
    localparam int NAC_WRITE_TICKS = 4;
    localparam int NAC_SYNC_DEPTH = 3;

endpackage

// *** src/nac_mem_if.sv ***
// Interface between the register front end and the array sequencer.
// Assumes both sides run on the system clock.
`timescale 1ns/1ps
interface nac_mem_if;
    logic read_go;
    logic write_go;
    logic [8:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic read_done;
    logic write_done;

    modport ctrl
    (
        output read_go,
        output write_go,
        output addr,
        output wdata,
        input rdata,
        input read_done,
        input write_done
    );
    modport seq
    (
        input read_go,
        input write_go,
        input addr,
        input wdata,
        output rdata,
        output read_done,
        output write_done
    );
endinterface

// *** src/nac_seq.sv ***
// Array sequencer: holds the byte array, times reads on the system clock
// and times writes by a slow timer tick from another clock domain.
// Assumes go pulses are single cycle and never overlap a busy cycle.
`timescale 1ns/1ps
module nac_seq
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Slow write timer tick level from outside the clock domain
    input wire logic slow_subsidiary_clock,
    // Front end
    nac_mem_if.seq mem
);
    import nac_pkg::*;

    typedef enum {NAC_IDLE, NAC_READ, NAC_WRITE} nac_state_t;

    nac_state_t state_r;
    logic [7:0] array_r [512];
    logic [NAC_SYNC_DEPTH-1:0] sync_r;
    logic tick;
    logic slow_lvl_r;
    logic [7:0] cnt_r;
    logic [8:0] addr_r;
    logic [7:0] wdata_r;
    logic [7:0] rdata_r;

    // The first stage is read only by the second one.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            sync_r <= '0;
        else
            sync_r <= {sync_r[NAC_SYNC_DEPTH-2:0], slow_subsidiary_clock};
    end

    // The filtered level moves only when stages two and three agree, so a
    // level still settling in the chain never counts as an edge.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            slow_lvl_r <= 1'b0;
        else if (sync_r[1] == sync_r[2])
            slow_lvl_r <= sync_r[2];
    end

    // Rising edge of the filtered slow timer level.
    assign tick = (sync_r[1] == sync_r[2]) && sync_r[2] && !slow_lvl_r;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= NAC_IDLE;
            cnt_r <= 8'h00;
            addr_r <= NAC_RST_ADDR;
            wdata_r <= NAC_RST_REG;
        end
        else
        begin
            case (state_r)
                NAC_IDLE:
                begin
                    cnt_r <= 8'h00;
                    addr_r <= mem.addr;
                    wdata_r <= mem.wdata;
                    if (mem.write_go)
                        state_r <= NAC_WRITE;
                    else if (mem.read_go)
                        state_r <= NAC_READ;
                end
                NAC_READ:
                begin
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r == 8'(NAC_READ_CYC - 1))
                        state_r <= NAC_IDLE;
                end
                // RQ18 async write timing
                NAC_WRITE:
                begin
                    if (tick)
                        cnt_r <= cnt_r + 8'h01;
                    if (tick && cnt_r == 8'(NAC_WRITE_TICKS - 1))
                        state_r <= NAC_IDLE;
                end
                default: state_r <= NAC_IDLE;
            endcase
        end
    end

    assign mem.read_done = (state_r == NAC_READ) &&
        (cnt_r == 8'(NAC_READ_CYC - 1));
    assign mem.write_done = (state_r == NAC_WRITE) && tick &&
        (cnt_r == 8'(NAC_WRITE_TICKS - 1));

    // The array has no reset; it models non-volatile content.
    always_ff @(posedge clock)
    begin
        if (mem.write_done)
            array_r[addr_r] <= wdata_r;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rdata_r <= NAC_RST_REG;
        else if (state_r == NAC_READ)
            rdata_r <= array_r[addr_r];
    end

    assign mem.rdata = rdata_r;
endmodule

// *** src/nac_top.sv ***
// Data EEPROM access controller: special function registers for address,
// byte buffer and control, plus the write-end interrupt flags.
// Assumes the CPU gives one-cycle write strobes and reads combinationally.
`timescale 1ns/1ps
module nac_top
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Variant strap, held constant in operation
    input wire logic [1:0] capacity_sel,
    // Register port
    input wire logic [2:0] reg_sel,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Interrupt side
    input wire logic global_irq_enable,
    input wire logic nvm_irq_enable,
    input wire logic mf_irq_enable,
    input wire logic stack_full,
    input wire logic nvm_irq_flag_clr,
    input wire logic mf_irq_flag_clr,
    output logic nvm_irq_flag,
    output logic mf_irq_flag,
    output logic vector_request,
    // Slow timer
    input wire logic slow_subsidiary_clock
);
    import nac_pkg::*;

    nac_mem_if mem ();

    logic [7:0] addr_low_r;
    logic addr_high_r;
    logic [7:0] buf_r;
    logic program_permit_r;
    logic write_go_r;
    logic fetch_permit_r;
    logic read_go_r;
    logic nvm_flag_r;
    logic mf_flag_r;
    logic ctl_wr;
    logic start_write;
    logic start_read;
    logic [8:0] full_addr;

    assign ctl_wr = reg_wr && (reg_sel == NAC_SEL_CONTROL);

    // =========================================================
    // Trigger qualification
    // RQ7 needs prior permission
    assign start_write = ctl_wr && reg_wdata[NAC_BIT_WRITE_GO] &&
        program_permit_r && !write_go_r && !read_go_r;
    // RQ10 needs prior permission
    assign start_read = ctl_wr && reg_wdata[NAC_BIT_READ_GO] &&
        fetch_permit_r && !read_go_r && !write_go_r && !start_write;

    // =========================================================
    // Address registers
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_low_r <= NAC_RST_REG;
            addr_high_r <= 1'b0;
        end
        else if (reg_wr && reg_sel == NAC_SEL_ADDR_LOW)
        begin
            // RQ1 seven bits only
            if (capacity_sel == NAC_CAP_128)
                addr_low_r <= {1'b0, reg_wdata[6:0]};
            // RQ2 full eight bits
            else
                addr_low_r <= reg_wdata;
        end
        // RQ3 high bit zero
        else if (reg_wr && reg_sel == NAC_SEL_ADDR_HIGH &&
                 capacity_sel == NAC_CAP_512)
            addr_high_r <= reg_wdata[0];
    end

    assign full_addr = {addr_high_r, addr_low_r};

    // =========================================================
    // Byte buffer
    // RQ14 read byte held
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            buf_r <= NAC_RST_REG;
        else if (mem.read_done)
            buf_r <= mem.rdata;
        else if (reg_wr && reg_sel == NAC_SEL_BYTE_BUF)
            buf_r <= reg_wdata;
    end

    // =========================================================
    // Control register
    // RQ19 power-on clears permission
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            program_permit_r <= 1'b0;
            fetch_permit_r <= 1'b0;
        end
        // RQ5 write permission bit
        // RQ8 read permission bit
        else if (ctl_wr)
        begin
            program_permit_r <= reg_wdata[NAC_BIT_PROGRAM_PERMIT];
            fetch_permit_r <= reg_wdata[NAC_BIT_FETCH_PERMIT];
        end
    end

    // Triggers cannot be cleared by software; only completion or reset ends them.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            write_go_r <= 1'b0;
            read_go_r <= 1'b0;
        end
        else
        begin
            // RQ6 self-clearing write trigger
            if (start_write)
                write_go_r <= 1'b1;
            else if (mem.write_done)
                write_go_r <= 1'b0;
            // RQ9 self-clearing read trigger
            if (start_read)
                read_go_r <= 1'b1;
            else if (mem.read_done)
                read_go_r <= 1'b0;
        end
    end

    // =========================================================
    // Sequencer requests
    assign mem.write_go = start_write;
    assign mem.read_go = start_read;
    assign mem.addr = full_addr;
    assign mem.wdata = buf_r;

    nac_seq u_seq
    (
        .clock(clock),
        .rst_n(rst_n),
        .slow_subsidiary_clock(slow_subsidiary_clock),
        .mem(mem)
    );

    // =========================================================
    // Interrupt flags
    // RQ20 write end sets flags
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nvm_flag_r <= 1'b0;
            mf_flag_r <= 1'b0;
        end
        else
        begin
            // Set wins over a clear in the same cycle.
            if (mem.write_done)
                nvm_flag_r <= 1'b1;
            else if (nvm_irq_flag_clr)
                nvm_flag_r <= 1'b0;
            if (mem.write_done)
                mf_flag_r <= 1'b1;
            else if (mf_irq_flag_clr)
                mf_flag_r <= 1'b0;
        end
    end

    assign nvm_irq_flag = nvm_flag_r;
    assign mf_irq_flag = mf_flag_r;
    // RQ21 all enables, stack room
    assign vector_request = nvm_flag_r && mf_flag_r && global_irq_enable &&
        nvm_irq_enable && mf_irq_enable && !stack_full;

    // =========================================================
    // Read back
    always_comb
    begin
        case (reg_sel)
            NAC_SEL_ADDR_LOW: reg_rdata = addr_low_r;
            NAC_SEL_ADDR_HIGH: reg_rdata = {7'h00, addr_high_r};
            NAC_SEL_BYTE_BUF: reg_rdata = buf_r;
            // RQ4 upper bits zero
            NAC_SEL_CONTROL: reg_rdata = {4'h0, program_permit_r,
                write_go_r, fetch_permit_r, read_go_r};
            default: reg_rdata = 8'h00;
        endcase
    end
endmodule

// *** dv/nac_sva.sv ***
// Checker for the EEPROM access controller, bound to its top module.
// Assumes register reads are combinational from the stored registers.
`timescale 1ns/1ps
module nac_sva
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [1:0] capacity_sel,
    input wire logic [2:0] reg_sel,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Interrupt side
    input wire logic global_irq_enable,
    input wire logic nvm_irq_enable,
    input wire logic mf_irq_enable,
    input wire logic stack_full,
    input wire logic nvm_irq_flag_clr,
    input wire logic nvm_irq_flag,
    input wire logic mf_irq_flag,
    input wire logic vector_request
);
    import nac_pkg::*;
    logic ctl;
    assign ctl = reg_sel == NAC_SEL_CONTROL;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // =========================================================
    // Register layout
    a_ctrl_upper_zero: assert property (
        ctl |-> reg_rdata[7:4] == 4'h0)
        else $error("control upper bits set");
    a_high_addr_bits: assert property (
        reg_sel == NAC_SEL_ADDR_HIGH |-> reg_rdata[7:1] == 7'h00)
        else $error("address high upper bits set");
    a_small_addr_top: assert property (
        capacity_sel == NAC_CAP_128 && reg_sel == NAC_SEL_ADDR_LOW
        |-> !reg_rdata[7])
        else $error("small variant address bit 7 set");
    a_ctrl_reset_zero: assert property (
        $rose(rst_n) && ctl |-> reg_rdata == 8'h00)
        else $error("control not zero after reset");

    // =========================================================
    // Trigger gating
    a_write_gated: assert property (
        ctl && reg_wr && reg_wdata[2] && !reg_rdata[3] && !reg_rdata[2]
        |=> !ctl || !reg_rdata[2])
        else $error("write started without permit");
    a_read_gated: assert property (
        ctl && reg_wr && reg_wdata[0] && !reg_rdata[1] && !reg_rdata[0]
        |=> !ctl || !reg_rdata[0])
        else $error("read started without permit");

    // =========================================================
    // Interrupt flags
    a_flags_together: assert property (
        $rose(nvm_irq_flag) |-> mf_irq_flag)
        else $error("flags not raised together");
    a_flag_sticky: assert property (
        nvm_irq_flag && !nvm_irq_flag_clr |=> nvm_irq_flag)
        else $error("flag dropped without clear");
    a_vector_gate: assert property (
        vector_request == (nvm_irq_flag && mf_irq_flag && global_irq_enable
        && nvm_irq_enable && mf_irq_enable && !stack_full))
        else $error("vector request mismatch");

    c_write_start: cover property (ctl && reg_wr && reg_wdata[2]
        && reg_rdata[3]);
    c_read_start: cover property (ctl && reg_wr && reg_wdata[0]
        && reg_rdata[1]);
    c_vector: cover property (vector_request);
endmodule

// *** dv/nac_tb_top.sv ***
// Self-checking bench for the EEPROM access controller top module.
// Assumes the package is compiled first; the checker is bound below.
`timescale 1ns/1ps
module nac_tb_top;
    import nac_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic slow_clk = 1'b0;
    logic [1:0] capacity_sel = 2'h0;
    logic [2:0] reg_sel = 3'h3;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    // Bit 0 global, 1 nvm, 2 multi-function enable, 3 stack full.
    logic [3:0] irq_en = 4'h0;
    logic nvm_clr = 1'b0;
    logic mf_clr = 1'b0;
    logic nvm_irq_flag;
    logic mf_irq_flag;
    logic vector_request;
    logic [7:0] lfsr_r = 8'h49;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;

    always #20 clock = ~clock;
    // Free-running slow timer, phase unrelated to the system clock.
    // stable before writes
    always #150 slow_clk = ~slow_clk;

    nac_top nac_top_i
    (
        .clock(clock), .rst_n(rst_n), .capacity_sel(capacity_sel),
        .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .global_irq_enable(irq_en[0]),
        .nvm_irq_enable(irq_en[1]), .mf_irq_enable(irq_en[2]),
        .stack_full(irq_en[3]), .nvm_irq_flag_clr(nvm_clr),
        .mf_irq_flag_clr(mf_clr), .nvm_irq_flag(nvm_irq_flag),
        .mf_irq_flag(mf_irq_flag), .vector_request(vector_request),
        .slow_subsidiary_clock(slow_clk)
    );

    // =========================================================
    // Helpers
    function automatic logic [7:0] rnd();
        lfsr_r = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        return lfsr_r;
    endfunction

    function automatic logic [7:0] addr_exp(input int c, input int hi,
        input logic [7:0] v);
        if (hi)
            return (c == NAC_CAP_512) ? (v & 8'h01) : 8'h00;
        return (c == NAC_CAP_128) ? (v & 8'h7f) : v;
    endfunction

    task automatic chk(input string name, input logic [7:0] exp,
        input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", name, exp, got);
        end
    endtask

    // Strobe is left high; a following rd, idle or poll lowers it, so a chain of
    // writes lands in consecutive cycles.
    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        reg_sel = sel;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
    endtask

    task automatic rd(input logic [2:0] sel, input logic [7:0] exp,
        input string name);
        reg_wr = 1'b0;
        reg_sel = sel;
        #1;
        chk(name, exp, reg_rdata);
        @(negedge clock);
    endtask

    task automatic idle(input int n);
        reg_wr = 1'b0;
        repeat (n) @(negedge clock);
    endtask

    task automatic poll(input int b);
        int n;
        n = 0;
        reg_wr = 1'b0;
        reg_sel = NAC_SEL_CONTROL;
        #1;
        while (reg_rdata[b] !== 1'b0 && n < 300)
        begin
            @(negedge clock);
            n++;
        end
        chk("busy bit", 8'h00, {7'h00, reg_rdata[b]});
        @(negedge clock);
    endtask

    task automatic final_report();
        $display("Checks %0d, errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            final_report();
        end
    end

    // =========================================================
    // Main sequence, once per capacity variant
    initial
    begin
        logic [7:0] a;
        logic [7:0] h;
        logic [7:0] d;
        for (int c = 0; c < 3; c++)
        begin
            rst_n = 1'b0;
            reg_sel = NAC_SEL_CONTROL;
            capacity_sel = c[1:0];
            repeat (2) @(negedge clock);
            rst_n = 1'b1;
            for (int s = 0; s < 5; s++)
                rd(s[2:0], 8'h00, "reset value");
            a = rnd();
            h = rnd();
            d = rnd();
            wr(NAC_SEL_ADDR_LOW, a);
            wr(NAC_SEL_ADDR_HIGH, h);
            wr(NAC_SEL_CONTROL, 8'hf0);
            rd(NAC_SEL_ADDR_LOW, addr_exp(c, 0, a), "addr low");
            rd(NAC_SEL_ADDR_HIGH, addr_exp(c, 1, h), "addr high");
            rd(NAC_SEL_CONTROL, 8'h00, "control upper");
            wr(NAC_SEL_CONTROL, 8'h04);
            rd(NAC_SEL_CONTROL, 8'h00, "write no permit");
            wr(NAC_SEL_CONTROL, 8'h0c);
            rd(NAC_SEL_CONTROL, 8'h08, "write same permit");
            wr(NAC_SEL_CONTROL, 8'h00);
            wr(NAC_SEL_BYTE_BUF, d);
            wr(NAC_SEL_CONTROL, 8'h08);
            wr(NAC_SEL_CONTROL, 8'h0c);
            rd(NAC_SEL_CONTROL, 8'h0c, "write busy");
            poll(NAC_BIT_WRITE_GO);
            chk("nvm flag", 8'h01, {7'h00, nvm_irq_flag});
            chk("mf flag", 8'h01, {7'h00, mf_irq_flag});
            for (int e = 0; e < 16; e++)
            begin
                irq_en = e[3:0];
                #1;
                chk("vector", {7'h00, e == 7},
                    {7'h00, vector_request});
                @(negedge clock);
            end
            irq_en = 4'h0;
            nvm_clr = 1'b1;
            idle(1);
            nvm_clr = 1'b0;
            chk("nvm cleared", 8'h00, {7'h00, nvm_irq_flag});
            chk("mf kept", 8'h01, {7'h00, mf_irq_flag});
            mf_clr = 1'b1;
            idle(1);
            mf_clr = 1'b0;
            wr(NAC_SEL_BYTE_BUF, ~d);
            wr(NAC_SEL_CONTROL, 8'h01);
            rd(NAC_SEL_CONTROL, 8'h00, "read no permit");
            rd(NAC_SEL_BYTE_BUF, ~d, "buffer kept");
            wr(NAC_SEL_ADDR_LOW, a);
            wr(NAC_SEL_ADDR_HIGH, h);
            wr(NAC_SEL_CONTROL, 8'h02);
            wr(NAC_SEL_CONTROL, 8'h03);
            rd(NAC_SEL_CONTROL, 8'h03, "read busy");
            poll(NAC_BIT_READ_GO);
            idle(10);
            rd(NAC_SEL_BYTE_BUF, d, "read data");
            chk("no read flag", 8'h00, {7'h00, mf_irq_flag});
        end
        final_report();
    end
endmodule

bind nac_top nac_sva nac_sva_i
(
    .clock(clock), .rst_n(rst_n), .capacity_sel(capacity_sel),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .global_irq_enable(global_irq_enable),
    .nvm_irq_enable(nvm_irq_enable), .mf_irq_enable(mf_irq_enable),
    .stack_full(stack_full), .nvm_irq_flag_clr(nvm_irq_flag_clr),
    .nvm_irq_flag(nvm_irq_flag), .mf_irq_flag(mf_irq_flag),
    .vector_request(vector_request)
);
